// ==== src/mcsb_consts.svh ====
`ifndef MCSB_CONSTS_SVH
`define MCSB_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MCSB_OFS_CTRL      12'h000
`define MCSB_OFS_STAT      12'h004
`define MCSB_OFS_IRQ_EN    12'h008
`define MCSB_OFS_IRQ_ST    12'h00c
`define MCSB_OFS_ADC_LO    12'h010
`define MCSB_OFS_ADC_HI    12'h04c
`define MCSB_OFS_I2C_LO    12'h050
`define MCSB_OFS_I2C_HI    12'h064
`define MCSB_OFS_DMA_LO    12'h080
`define MCSB_OFS_DMA_HI    12'h0bc
`define MCSB_OFS_APP_LO    12'h100
`define MCSB_OFS_APP_HI    12'h13c
`define MCSB_OFS_APP_ST    12'h160
`define MCSB_OFS_APP_CMD   12'h164
`define MCSB_OFS_FW_ID     12'h1fc

// ****************************************
// Field positions
// ****************************************
`define MCSB_CTRL_DIS_LSB  4
`define MCSB_CTRL_GATE_BIT 0
`define MCSB_ST_LOSS_LSB   16
`define MCSB_ST_IOCAL_BIT  12
`define MCSB_ST_REAR_BIT   8
`define MCSB_ST_ALGN_LSB   4
`define MCSB_ST_MSI_BIT    3
`define MCSB_ST_INTX_BIT   2
`define MCSB_ST_INV_BIT    0

// ****************************************
// Reset values and timing
// ****************************************
`define MCSB_RST_DIS       4'h0
`define MCSB_RST_GATE      1'h0
`define MCSB_RST_LOSS      4'h0
`define MCSB_FWD_TMO_MAX   5'h0f

`endif

// ==== src/mcsb_pkg.sv ====
package mcsb_pkg;

    typedef enum logic [0:0] {
        MCSB_ST_IDLE = 1'b0,
        MCSB_ST_WAIT = 1'b1
    } mcsb_state_e;

    typedef enum logic [3:0] {
        MCSB_R_NONE   = 4'h0,
        MCSB_R_CTRL   = 4'h1,
        MCSB_R_STAT   = 4'h2,
        MCSB_R_IRQ    = 4'h3,
        MCSB_R_ADC    = 4'h4,
        MCSB_R_I2C    = 4'h5,
        MCSB_R_DMA    = 4'h6,
        MCSB_R_APP    = 4'h7,
        MCSB_R_APPST  = 4'h8,
        MCSB_R_APPCMD = 4'h9,
        MCSB_R_FWID   = 4'ha
    } mcsb_region_e;

endpackage : mcsb_pkg

// ==== src/mcsb_bank.sv ====
// Notes on behaviour
// - Control bits 7:4 disable deserializer units A to D; reset zero.
// - Clearing a set disable bit pulses that unit's reset.
// - Control bit 0 gates all module interrupts; reset zero.
// - Status 19:16 sticky calibration loss flags, write one clears.
// - Status 12 shows I/O impedance calibration done.
// - Status 8 shows rear module presence; reset zero.
// - Status 7:4 show per-unit deserializer alignment done.
// - Status 3 shows message interrupts, single vector used.
// - Status 2 shows legacy wire interrupts; follows the input live, not reset.
// - Status 0 flags invalid interrupt setup; no interrupt then.
// - Offsets 0x10 to 0x4C go to converter sample registers.
// - Offsets 0x50 to 0x64 go to the I2C bridge.
// - Offsets 0x80 to 0xBC go to the four DMA engines.
// - Capture unit registers 0x100 to 0x13C, gaps at 0x110, 0x120 and 0x130.
// - Decode 0x160, 0x164 and 0x1FC; rest reserved.
// - Each bridge instance owns its own register set.
// - Falling presence input disables rear module interfaces three clock edges later.
`include "mcsb_consts.svh"

module mcsb_bank
    import mcsb_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [11:0]  req_addr_i,
    input  wire logic         req_wr_i,
    input  wire logic         req_rd_i,
    input  wire logic [31:0]  req_wdata_i,
    output logic              req_ready_o,
    output logic              rsp_valid_o,
    output logic [31:0]       rsp_rdata_o,
    output mcsb_region_e      fwd_sel_o,
    output logic              fwd_wr_o,
    output logic              fwd_rd_o,
    output logic [11:0]       fwd_addr_o,
    output logic [31:0]       fwd_wdata_o,
    input  wire logic         fwd_ack_i,
    input  wire logic [31:0]  fwd_rdata_i,
    input  wire logic [3:0]   cal_loss_event_i,
    input  wire logic         io_impedance_cal_done_i,
    input  wire logic         rear_module_present_input_i,
    input  wire logic [3:0]   deser_aligned_i,
    input  wire logic         irq_mode_message_i,
    input  wire logic         irq_mode_legacy_wire_i,
    input  wire logic         irq_mode_invalid_i,
    output logic [3:0]        deser_unit_disable_o,
    output logic [3:0]        deser_unit_reset_o,
    output logic              global_irq_gate_o,
    output logic              irq_allowed_o,
    output logic              rear_module_present_o
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        mcsb_state_e  state;
        logic         ready;
        logic [3:0]   dis;
        logic         gate;
        logic [3:0]   loss;
        logic         rear_s1;
        logic         rear_s2;
        logic         iocal_s1;
        logic         iocal_s2;
        logic [3:0]   algn_s1;
        logic [3:0]   algn_s2;
        logic         rear_en;
        logic [3:0]   dreset;
        logic         irq_ok;
        logic         rvalid;
        logic [31:0]  rdata;
        mcsb_region_e sel;
        logic         fwr;
        logic         frd;
        logic [11:0]  faddr;
        logic [31:0]  fwdata;
        logic [4:0]   tmo;
    } mcsb_regs_s;

    mcsb_regs_s   st_reg;
    mcsb_regs_s   st_next;
    mcsb_region_e req_region;
    logic [3:0]   dis_fall;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic mcsb_region_e decode(input logic [11:0] addr);
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        if (a == `MCSB_OFS_CTRL)
            return MCSB_R_CTRL;
        if (a == `MCSB_OFS_STAT)
            return MCSB_R_STAT;
        if (a == `MCSB_OFS_IRQ_EN || a == `MCSB_OFS_IRQ_ST)
            return MCSB_R_IRQ;
        if (a >= `MCSB_OFS_ADC_LO && a <= `MCSB_OFS_ADC_HI)
            return MCSB_R_ADC;
        if (a >= `MCSB_OFS_I2C_LO && a <= `MCSB_OFS_I2C_HI)
            return MCSB_R_I2C;
        if (a >= `MCSB_OFS_DMA_LO && a <= `MCSB_OFS_DMA_HI)
            return MCSB_R_DMA;
        if (a >= `MCSB_OFS_APP_LO && a <= `MCSB_OFS_APP_HI
            && (a[3:0] != 4'h0 || a == `MCSB_OFS_APP_LO))
            return MCSB_R_APP;
        if (a == `MCSB_OFS_APP_ST)
            return MCSB_R_APPST;
        if (a == `MCSB_OFS_APP_CMD)
            return MCSB_R_APPCMD;
        if (a == `MCSB_OFS_FW_ID)
            return MCSB_R_FWID;
        return MCSB_R_NONE;
    endfunction : decode

    function automatic logic [31:0] ctrl_word(input logic [3:0] dis,
                                              input logic       gate);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`MCSB_CTRL_DIS_LSB +: 4] = dis;
        w[`MCSB_CTRL_GATE_BIT]     = gate;
        return w;
    endfunction : ctrl_word

    function automatic logic [31:0] status_word(input mcsb_regs_s r,
                                                input logic       msi,
                                                input logic       intx,
                                                input logic       inv);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`MCSB_ST_LOSS_LSB +: 4] = r.loss;
        w[`MCSB_ST_IOCAL_BIT]     = r.iocal_s2;
        w[`MCSB_ST_REAR_BIT]      = r.rear_s2;
        w[`MCSB_ST_ALGN_LSB +: 4] = r.algn_s2;
        w[`MCSB_ST_MSI_BIT]       = msi;
        w[`MCSB_ST_INTX_BIT]      = intx;
        w[`MCSB_ST_INV_BIT]       = inv;
        return w;
    endfunction : status_word

    assign req_region = decode(req_addr_i);
    assign dis_fall   = st_reg.dis & ~st_next.dis;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next          = st_reg;
        st_next.rvalid   = 1'b0;
        st_next.fwr      = 1'b0;
        st_next.frd      = 1'b0;
        st_next.rear_s1  = rear_module_present_input_i;
        st_next.rear_s2  = st_reg.rear_s1;
        st_next.iocal_s1 = io_impedance_cal_done_i;
        st_next.iocal_s2 = st_reg.iocal_s1;
        st_next.algn_s1  = deser_aligned_i;
        st_next.algn_s2  = st_reg.algn_s1;
        st_next.rear_en  = st_reg.rear_s2;
        st_next.loss     = st_reg.loss | cal_loss_event_i;
        unique case (st_reg.state)
            MCSB_ST_IDLE: begin
                if (req_wr_i) begin
                    unique case (req_region)
                        MCSB_R_CTRL: begin
                            st_next.dis  = req_wdata_i[
                                `MCSB_CTRL_DIS_LSB +: 4];
                            st_next.gate = req_wdata_i[
                                `MCSB_CTRL_GATE_BIT];
                        end
                        MCSB_R_STAT: begin
                            // Set wins over clear
                            st_next.loss = (st_reg.loss
                                & ~req_wdata_i[`MCSB_ST_LOSS_LSB +: 4])
                                | cal_loss_event_i;
                        end
                        MCSB_R_NONE: begin
                        end
                        default: begin
                            st_next.fwr    = 1'b1;
                            st_next.sel    = req_region;
                            st_next.faddr  = req_addr_i;
                            st_next.fwdata = req_wdata_i;
                        end
                    endcase
                end else if (req_rd_i) begin
                    unique case (req_region)
                        MCSB_R_CTRL: begin
                            st_next.rvalid = 1'b1;
                            st_next.rdata  = ctrl_word(st_reg.dis,
                                                       st_reg.gate);
                        end
                        MCSB_R_STAT: begin
                            st_next.rvalid = 1'b1;
                            st_next.rdata  = status_word(st_reg,
                                irq_mode_message_i, irq_mode_legacy_wire_i,
                                irq_mode_invalid_i);
                        end
                        MCSB_R_NONE: begin
                            st_next.rvalid = 1'b1;
                            st_next.rdata  = 32'h0000_0000;
                        end
                        default: begin
                            st_next.frd   = 1'b1;
                            st_next.sel   = req_region;
                            st_next.faddr = req_addr_i;
                            st_next.state = MCSB_ST_WAIT;
                            st_next.ready = 1'b0;
                            st_next.tmo   = 5'h00;
                        end
                    endcase
                end
            end
            MCSB_ST_WAIT: begin
                if (fwd_ack_i) begin
                    st_next.rvalid = 1'b1;
                    st_next.rdata  = fwd_rdata_i;
                    st_next.state  = MCSB_ST_IDLE;
                    st_next.ready  = 1'b1;
                end else if (st_reg.tmo == `MCSB_FWD_TMO_MAX) begin
                    // Silent target must not hang the host
                    st_next.rvalid = 1'b1;
                    st_next.rdata  = 32'h0000_0000;
                    st_next.state  = MCSB_ST_IDLE;
                    st_next.ready  = 1'b1;
                end else begin
                    st_next.tmo = st_reg.tmo + 5'h01;
                end
            end
        endcase
        st_next.dreset = st_reg.dis & ~st_next.dis;
        st_next.irq_ok = st_next.gate & ~irq_mode_invalid_i
            & (irq_mode_message_i | irq_mode_legacy_wire_i);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg       <= '0;
            st_reg.ready <= 1'b1;
            st_reg.dis   <= `MCSB_RST_DIS;
            st_reg.gate  <= `MCSB_RST_GATE;
            st_reg.loss  <= `MCSB_RST_LOSS;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign req_ready_o           = st_reg.ready;
    assign rsp_valid_o           = st_reg.rvalid;
    assign rsp_rdata_o           = st_reg.rdata;
    assign fwd_sel_o             = st_reg.sel;
    assign fwd_wr_o              = st_reg.fwr;
    assign fwd_rd_o              = st_reg.frd;
    assign fwd_addr_o            = st_reg.faddr;
    assign fwd_wdata_o           = st_reg.fwdata;
    assign deser_unit_disable_o  = st_reg.dis;
    assign deser_unit_reset_o    = st_reg.dreset;
    assign global_irq_gate_o     = st_reg.gate;
    assign irq_allowed_o         = st_reg.irq_ok;
    assign rear_module_present_o = st_reg.rear_en;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic ctrl_wr_w;
    logic stat_rd_w;
    assign ctrl_wr_w = ce_i && req_wr_i && st_reg.state == MCSB_ST_IDLE
        && req_region == MCSB_R_CTRL;
    assign stat_rd_w = ce_i && !req_wr_i && req_rd_i
        && st_reg.state == MCSB_ST_IDLE && req_region == MCSB_R_STAT;

    sequence s_fwd_issue;
        ce_i && !req_wr_i && req_rd_i && st_reg.state == MCSB_ST_IDLE
            && req_region == MCSB_R_ADC;
    endsequence
    sequence s_fwd_ack;
        ce_i && fwd_ack_i && st_reg.state == MCSB_ST_WAIT;
    endsequence
    sequence s_fwd_timeout;
        ce_i && !fwd_ack_i && st_reg.state == MCSB_ST_WAIT
            && st_reg.tmo == `MCSB_FWD_TMO_MAX;
    endsequence

    ctrl_write_a: assert property (ctrl_wr_w |=>
        deser_unit_disable_o == $past(req_wdata_i[7:4])
        && global_irq_gate_o == $past(req_wdata_i[0]))
        else $error("control write not stored");
    deser_reset_a: assert property (ce_i && |dis_fall |=>
        deser_unit_reset_o == $past(dis_fall))
        else $error("deserializer reset pulse wrong");
    irq_gate_a: assert property (irq_allowed_o |->
        global_irq_gate_o)
        else $error("interrupt allowed while gate off");
    irq_invalid_a: assert property (ce_i && irq_mode_invalid_i |=>
        !irq_allowed_o)
        else $error("interrupt allowed with invalid mode");
    loss_sticky_a: assert property (ce_i && cal_loss_event_i[0] |=>
        st_reg.loss[0] ##1 st_reg.loss[0] || $past(ce_i && req_wr_i))
        else $error("loss flag not sticky");
    rear_drop_a: assert property (ce_i && !st_reg.rear_s2 |=>
        !rear_module_present_o)
        else $error("rear module stays enabled");
    status_read_a: assert property (stat_rd_w |=> rsp_valid_o
        && rsp_rdata_o[8] == $past(st_reg.rear_s2)
        && rsp_rdata_o[31:20] == 12'h000)
        else $error("status read wrong");
    adc_route_a: assert property (s_fwd_issue |=> fwd_rd_o
        && fwd_sel_o == MCSB_R_ADC && !req_ready_o)
        else $error("sample read not forwarded");
    fwd_return_a: assert property (s_fwd_ack |=> rsp_valid_o
        && rsp_rdata_o == $past(fwd_rdata_i) && req_ready_o)
        else $error("forwarded read not returned");
    resv_read_a: assert property (ce_i && req_rd_i && !req_wr_i
        && st_reg.state == MCSB_ST_IDLE && req_region == MCSB_R_NONE
        |=> rsp_valid_o && rsp_rdata_o == 32'h0000_0000)
        else $error("reserved offset not zero");
    loss_set_a: assert property (ce_i && |cal_loss_event_i |=>
        (st_reg.loss & $past(cal_loss_event_i)) == $past(cal_loss_event_i))
        else $error("loss event lost");
    loss_clear_a: assert property (ce_i && req_wr_i
        && st_reg.state == MCSB_ST_IDLE && req_region == MCSB_R_STAT
        |=> st_reg.loss == (($past(st_reg.loss)
        & ~$past(req_wdata_i[19:16])) | $past(cal_loss_event_i)))
        else $error("loss flag clear wrong");
    stat_fields_a: assert property (stat_rd_w |=>
        rsp_rdata_o[12] == $past(st_reg.iocal_s2)
        && rsp_rdata_o[7:4] == $past(st_reg.algn_s2))
        else $error("status calibration fields wrong");
    irq_mode_a: assert property (stat_rd_w |=>
        rsp_rdata_o[3:0] == {$past(irq_mode_message_i),
        $past(irq_mode_legacy_wire_i), 1'h0, $past(irq_mode_invalid_i)})
        else $error("status mode bits wrong");
    reset_pulse_a: assert property (ce_i && !(|dis_fall) |=>
        deser_unit_reset_o == 4'h0)
        else $error("deserializer reset stays high");
    i2c_write_a: assert property (ce_i && req_wr_i
        && st_reg.state == MCSB_ST_IDLE && req_region == MCSB_R_I2C
        |=> fwd_wr_o && fwd_sel_o == MCSB_R_I2C
        && fwd_wdata_o == $past(req_wdata_i))
        else $error("bridge write not forwarded");
    ctrl_resv_a: assert property (ce_i && !req_wr_i && req_rd_i
        && st_reg.state == MCSB_ST_IDLE && req_region == MCSB_R_CTRL
        |=> rsp_rdata_o[31:8] == 24'h00_0000 && rsp_rdata_o[3:1] == 3'h0)
        else $error("control reserved bits set");
    fwd_timeout_a: assert property (s_fwd_timeout |=> rsp_valid_o
        && rsp_rdata_o == 32'h0000_0000 && req_ready_o)
        else $error("silent target hangs bus");

endmodule : mcsb_bank

// ==== verif/mcsb_fwd_model.sv ====
// ****************************************
// Downstream target answering forwarded reads
// ****************************************
module mcsb_fwd_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fwd_rd_i,
    input  wire logic [11:0] fwd_addr_i,
    input  wire logic [7:0]  lat_i,
    output logic             fwd_ack_o,
    output logic [31:0]      fwd_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  cnt;
    logic        busy;
    logic [11:0] addr;

    // Latency ff never answers; idle data toggles
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'h0;
            cnt <= 8'h0;
            addr <= 12'h0;
            fwd_ack_o <= 1'h0;
            fwd_rdata_o <= 32'h0;
        end else begin
            fwd_ack_o <= 1'h0;
            fwd_rdata_o <= ~fwd_rdata_o;
            if (fwd_rd_i) begin
                busy <= 1'h1;
                cnt <= lat_i;
                addr <= fwd_addr_i;
            end else if (busy && cnt == 8'h0 && lat_i != 8'hff) begin
                busy <= 1'h0;
                fwd_ack_o <= 1'h1;
                fwd_rdata_o <= {4'ha, addr, 4'h5, addr};
            end else if (busy && cnt != 8'h0) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
endmodule : mcsb_fwd_model

// ==== verif/module_control_status_bank_test.sv ====
module module_control_status_bank_test
    import mcsb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [11:0]  a;
        mcsb_region_e s;
    } mcsb_row_s;

    logic         clk_i = 1'h0;
    logic         rst_i = 1'h1;
    logic         ce_i = 1'h1;
    logic         req_wr_i = 1'h0;
    logic         req_rd_i = 1'h0;
    logic [11:0]  req_addr_i = 12'h0;
    logic [31:0]  req_wdata_i = 32'h0;
    logic [3:0]   cal_loss_event_i = 4'h0;
    logic [3:0]   deser_aligned_i = 4'h0;
    logic         io_impedance_cal_done_i = 1'h0;
    logic         rear_module_present_input_i = 1'h0;
    logic         irq_mode_message_i = 1'h0;
    logic         irq_mode_legacy_wire_i = 1'h0;
    logic         irq_mode_invalid_i = 1'h0;
    logic         fwd_ack_i, req_ready_o, rsp_valid_o, fwd_wr_o, fwd_rd_o;
    logic [31:0]  fwd_rdata_i, rsp_rdata_o, fwd_wdata_o, d, w_data;
    logic [11:0]  fwd_addr_o, w_addr;
    mcsb_region_e fwd_sel_o, w_sel;
    logic [3:0]   deser_unit_disable_o, deser_unit_reset_o, w_rst;
    logic         global_irq_gate_o, irq_allowed_o, rear_module_present_o;
    logic         w_fwd, fw;
    logic [7:0]   lat = 8'h0;
    int           error_cnt = 0;
    int           cmp_count = 0;
    mcsb_row_s    rows [17] = '{
        '{12'h008, MCSB_R_IRQ}, '{12'h010, MCSB_R_ADC},
        '{12'h04c, MCSB_R_ADC}, '{12'h050, MCSB_R_I2C},
        '{12'h064, MCSB_R_I2C}, '{12'h068, MCSB_R_NONE},
        '{12'h080, MCSB_R_DMA}, '{12'h0bc, MCSB_R_DMA},
        '{12'h0c0, MCSB_R_NONE}, '{12'h104, MCSB_R_APP},
        '{12'h110, MCSB_R_NONE}, '{12'h134, MCSB_R_APP},
        '{12'h160, MCSB_R_APPST}, '{12'h164, MCSB_R_APPCMD},
        '{12'h168, MCSB_R_NONE}, '{12'h1fc, MCSB_R_FWID},
        '{12'hffc, MCSB_R_NONE}};

    mcsb_bank uut (
        .clk_i, .rst_i, .ce_i, .req_addr_i, .req_wr_i, .req_rd_i,
        .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .fwd_sel_o,
        .fwd_wr_o, .fwd_rd_o, .fwd_addr_o, .fwd_wdata_o, .fwd_ack_i,
        .fwd_rdata_i, .cal_loss_event_i, .io_impedance_cal_done_i,
        .rear_module_present_input_i, .deser_aligned_i, .irq_mode_message_i,
        .irq_mode_legacy_wire_i, .irq_mode_invalid_i, .deser_unit_disable_o,
        .deser_unit_reset_o, .global_irq_gate_o, .irq_allowed_o,
        .rear_module_present_o);

    mcsb_fwd_model fm (
        .clk_i, .rst_i, .fwd_rd_i(fwd_rd_o), .fwd_addr_i(fwd_addr_o),
        .lat_i(lat), .fwd_ack_o(fwd_ack_i), .fwd_rdata_o(fwd_rdata_i));

    always #12.5 clk_i = ~clk_i;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, n, g, e);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // Whole 32-bit words only
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        req_addr_i = a;
        req_wdata_i = v;
        req_wr_i = 1'h1;
        do @(posedge clk_i); while (req_ready_o !== 1'h1);
        #1;
        // Strobes last one cycle: catch them before the next edge
        w_fwd = fwd_wr_o;
        w_sel = fwd_sel_o;
        w_addr = fwd_addr_o;
        w_data = fwd_wdata_o;
        w_rst = deser_unit_reset_o;
        req_wr_i = 1'h0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        req_addr_i = a;
        req_rd_i = 1'h1;
        do @(posedge clk_i); while (req_ready_o !== 1'h1);
        #1;
        req_rd_i = 1'h0;
        v = 32'hdead_beef;
        for (int k = 0; k < 40; k++) begin
            if (rsp_valid_o === 1'h1) begin
                v = rsp_rdata_o;
                break;
            end
            tick(1);
        end
        tick(1);
    endtask : rd

    function automatic logic [31:0] st(input logic [3:0] l, input logic c,
        r, input logic [3:0] g, input logic m, t, v);
        return {12'h0, l, 3'h0, c, 3'h0, r, g, m, t, 1'h0, v};
    endfunction : st

    initial begin
        #(25ns * 5000);
        error_cnt++;
        conclude();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        tick(4);
        rst_i = 1'h0;
        chk("rdy", {31'h0, req_ready_o}, 32'h1);
        chk("dis", {28'h0, deser_unit_disable_o}, 32'h0);
        chk("gate", {31'h0, global_irq_gate_o}, 32'h0);
        rd(12'h000, d);
        chk("ctrl", d, 32'h0);
        rd(12'h004, d);
        chk("stat", d, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            lat = 8'(i % 3);
            fw = (rows[i].s != MCSB_R_NONE);
            wr(rows[i].a, ~{20'h0, rows[i].a});
            chk("fwr", {31'h0, w_fwd}, {31'h0, fw});
            if (fw) begin
                chk("sel", 32'(w_sel), 32'(rows[i].s));
                chk("fadr", {20'h0, w_addr}, {20'h0, rows[i].a});
                chk("fdat", w_data, ~{20'h0, rows[i].a});
            end
            rd(rows[i].a, d);
            chk("rdat", d, fw ? {4'ha, rows[i].a, 4'h5, rows[i].a}
                              : 32'h0);
        end
        $display("test map done");
        wr(12'h000, 32'hffff_ffff);
        chk("dis", {28'h0, deser_unit_disable_o}, 32'hf);
        rd(12'h000, d);
        chk("ctrl", d, 32'h0000_00f1);
        wr(12'h000, 32'h0000_0020);
        chk("prst", {28'h0, w_rst}, 32'hd);
        tick(1);
        chk("prst", {28'h0, deser_unit_reset_o}, 32'h0);
        chk("dis", {28'h0, deser_unit_disable_o}, 32'h2);
        $display("test control done");
        io_impedance_cal_done_i = 1'h1;
        rear_module_present_input_i = 1'h1;
        deser_aligned_i = 4'ha;
        irq_mode_message_i = 1'h1;
        wr(12'h000, 32'h0000_0001);
        tick(4);
        rd(12'h004, d);
        chk("stat", d, st(4'h0, 1'h1, 1'h1, 4'ha, 1'h1, 1'h0, 1'h0));
        chk("irq", {31'h0, irq_allowed_o}, 32'h1);
        chk("rear", {31'h0, rear_module_present_o}, 32'h1);
        irq_mode_invalid_i = 1'h1;
        rear_module_present_input_i = 1'h0;
        tick(4);
        chk("irq", {31'h0, irq_allowed_o}, 32'h0);
        chk("rear", {31'h0, rear_module_present_o}, 32'h0);
        rd(12'h004, d);
        chk("stat", d, st(4'h0, 1'h1, 1'h0, 4'ha, 1'h1, 1'h0, 1'h1));
        irq_mode_message_i = 1'h0;
        irq_mode_legacy_wire_i = 1'h1;
        irq_mode_invalid_i = 1'h0;
        tick(2);
        chk("irq", {31'h0, irq_allowed_o}, 32'h1);
        wr(12'h000, 32'h0000_0000);
        tick(2);
        chk("irq", {31'h0, irq_allowed_o}, 32'h0);
        $display("test status done");
        cal_loss_event_i = 4'h5;
        tick(1);
        cal_loss_event_i = 4'h0;
        wr(12'h004, 32'hfff0_ffff);
        rd(12'h004, d);
        chk("loss", d, st(4'h5, 1'h1, 1'h0, 4'ha, 1'h0, 1'h1, 1'h0));
        wr(12'h004, 32'h0001_0000);
        rd(12'h004, d);
        chk("loss", d, st(4'h4, 1'h1, 1'h0, 4'ha, 1'h0, 1'h1, 1'h0));
        // Event and clear meet at the same edge: the event must win
        fork
            wr(12'h004, 32'h0006_0000);
            begin
                cal_loss_event_i = 4'h2;
                tick(1);
                cal_loss_event_i = 4'h0;
            end
        join
        rd(12'h004, d);
        chk("loss", d, st(4'h2, 1'h1, 1'h0, 4'ha, 1'h0, 1'h1, 1'h0));
        $display("test loss done");
        lat = 8'hff;
        rd(12'h010, d);
        chk("tmo", d, 32'h0);
        ce_i = 1'h0;
        wr(12'h000, 32'h0000_00f0);
        ce_i = 1'h1;
        rd(12'h000, d);
        chk("frz", d, 32'h0);
        $display("test timeout done");
        wr(12'h000, 32'h0000_0031);
        chk("dis", {28'h0, deser_unit_disable_o}, 32'h3);
        rst_i = 1'h1;
        tick(1);
        rst_i = 1'h0;
        chk("dis", {28'h0, deser_unit_disable_o}, 32'h0);
        chk("gate", {31'h0, global_irq_gate_o}, 32'h0);
        rd(12'h000, d);
        chk("ctrl", d, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule : module_control_status_bank_test
